// file: common/sysctl_pkg.sv
// Shared constants for the reset status and system options register block
package sysctl_pkg;

   // Register select codes on the register port
   localparam logic [1:0] SEL_STATUS    = 2'h0;
   localparam logic [1:0] SEL_DBG_FORCE = 2'h1;
   localparam logic [1:0] SEL_OPTIONS   = 2'h2;

   // Reset cause status bit positions
   localparam int ST_POR_BIT   = 7;
   localparam int ST_PIN_BIT   = 6;
   localparam int ST_WDOG_BIT  = 5;
   localparam int ST_BAD_OPCODE_FLAG_BIT  = 4;
   localparam int ST_BAD_ADDRESS_FLAG_BIT  = 3;
   localparam int ST_LVD_BIT   = 1;

   // Reset cause status value after power-on
   localparam logic [7:0] STATUS_POR_VAL = 8'h82;
   localparam logic [7:0] STATUS_CLEAR   = 8'h00;

   // Debug force reset register
   localparam int         FORCE_RESET_BIT = 0;
   localparam logic [7:0] DBG_READ_VAL    = 8'h00;

   // System options one field positions, writable mask and reset value
   localparam int         OPT_TSEL_HI     = 7;
   localparam int         OPT_TSEL_LO     = 6;
   localparam int         OPT_STOP_BIT    = 5;
   localparam int         OPT_RSVD_BIT    = 4;
   localparam int         OPT_ROUTE_BIT   = 2;
   localparam logic [7:0] OPT_WR_MASK     = 8'hf4;
   localparam logic [7:0] OPT_RESET_VAL   = 8'hd0;
   localparam logic [1:0] TSEL_OFF        = 2'h0;

   // Watchdog service sequence values
   localparam logic [7:0] SVC_FIRST  = 8'h55;
   localparam logic [7:0] SVC_SECOND = 8'haa;

   // Unmapped read answer
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // Internal reset hold time, rounded up to whole cycles
   localparam int CLK_PERIOD_NS  = 10;
   localparam int RESET_HOLD_NS  = 100;
   localparam int HOLD_CYC       = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CNT_W     = 4;

   // Reset sequencer states
   typedef enum logic [0:0] {
      ST_RUN  = 1'b0,
      ST_HOLD = 1'b1
   } rst_state_t;

endpackage

// file: src/wdog_service_seq.sv
// Watchdog service sequence checker on the reset status address
`timescale 1ns/100ps
`default_nettype none

module wdog_service_seq (
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_hold,
   input  wire logic       i_wr,
   input  wire logic [7:0] i_wr_data,
   input  wire logic       i_wdog_enabled,
   input  wire logic       i_window_on,
   input  wire logic       i_last_quarter,
   output logic            o_wdog_clear,
   output logic            o_bad_write
);

   logic armed_q;
   logic is_first;
   logic is_second;
   logic bad;

   // Decode of the written value and of a write that must reset the part
   always_comb begin
      is_first  = (i_wr_data == sysctl_pkg::SVC_FIRST);
      is_second = (i_wr_data == sysctl_pkg::SVC_SECOND);
      bad       = i_wr && i_wdog_enabled &&
                  (!(is_first || is_second) || (i_window_on && !i_last_quarter));
   end

   // Armed only by a first value; any other write disarms, so a lone second value is harmless
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         armed_q <= 1'b0;
      end else if (i_hold) begin
         armed_q <= 1'b0;
      end else if (i_wr) begin
         armed_q <= is_first && !bad;
      end
   end

   // Clear pulse and bad write pulse
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_wdog_clear <= 1'b0;
         o_bad_write  <= 1'b0;
      end else begin
         o_wdog_clear <= !i_hold && i_wr && is_second && armed_q && !bad;
         o_bad_write  <= !i_hold && bad;
      end
   end

   AST_LONE_SECOND:
      assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
         (i_wr && is_second && !armed_q) |=> !o_wdog_clear)
      else $error("Second service value without first cleared the watchdog");

   AST_BAD_VALUE:
      assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
         (!i_hold && i_wr && i_wdog_enabled && !is_first && !is_second) |=> o_bad_write)
      else $error("Illegal status write did not flag a watchdog reset");

   AST_WINDOW_EARLY:
      assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
         (!i_hold && i_wr && i_wdog_enabled && i_window_on && !i_last_quarter) |=> o_bad_write && !o_wdog_clear)
      else $error("Early write in window mode did not reset");

endmodule

`default_nettype wire

// file: src/reset_status_and_options.sv
// Reset cause capture, watchdog service path, debug force reset and write-once options
//
// Notes on behaviour
// - Read-only flags record most recent reset cause
// - Debug forced reset leaves all status flags clear
// - Enabled watchdog: other status write values reset
// - First then second value clears watchdog, flags kept
// - Power-on sets power and low-voltage flags only
// - Low-voltage reset sets its flag, power flag kept
// - Other resets capture active sources, clear rest
// - Bit 6 marks external reset pin low
// - Bit 5 marks watchdog; zero timeout select blocks
// - Bit 4 marks illegal opcode, stop, background
// - Bit 3 marks access to unimplemented address
// - Debug register reads zero, user writes ignored
// - Debug host writing force bit resets part
// - Options accept first write only, always readable
// - Option bits 7:6 select watchdog timeout period
// - Option bit 5 allows stop, else opcode reset
// - Option bit 4 stored but without effect
// - Option bit 2 routes two-wire bus pins
// - Window mode with clock select set: early status write resets part
`timescale 1ns/100ps
`default_nettype none

module reset_status_and_options (
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_n,
   // Register port
   input  wire logic [1:0] i_reg_sel,
   input  wire logic       i_wr_en,
   input  wire logic       i_bdm_wr,
   input  wire logic [7:0] i_wr_data,
   input  wire logic       i_rd_en,
   // Reset sources
   input  wire logic       i_pin_reset_n,
   input  wire logic       i_lvd_trip,
   input  wire logic       i_low_volt_reset_enable,
   input  wire logic       i_wdog_timeout,
   input  wire logic       i_opcode_illegal,
   input  wire logic       i_stop_exec,
   input  wire logic       i_bgnd_exec,
   input  wire logic       i_background_mode_allow,
   input  wire logic       i_addr_illegal,
   // Settings held in system options two
   input  wire logic       i_watchdog_clock_sel,
   input  wire logic       i_watchdog_window_mode,
   input  wire logic       i_wdog_last_quarter,
   // Outputs
   output logic [7:0]      o_rd_data,
   output logic            o_sys_reset,
   output logic            o_wdog_clear,
   output logic [2:0]      o_wdog_period_sel,
   output logic            o_wdog_enable,
   output logic            o_stop_allow,
   output logic            o_twowire_pin_route
);

   localparam int           HCW = sysctl_pkg::HOLD_CNT_W;
   sysctl_pkg::rst_state_t state_q;
   logic [HCW-1:0]          hold_cnt_q;
   logic [7:0]              status_q;
   logic [7:0]              status_d;
   logic [7:0]              options_q;
   logic                    options_written_q;
   logic                    in_run;
   logic                    wr_any;
   logic                    status_wr;
   logic                    force_src;
   logic                    lvr_src;
   logic                    pin_src;
   logic                    wdog_src;
   logic                    bad_opcode_flag_src;
   logic                    bad_address_flag_src;
   logic                    entry;
   logic                    wdog_enabled;
   logic                    window_on;
   logic                    bad_write;
   logic                    after_por_q;

   // Register select decode, used by writes and by reads
   function automatic logic hit(input logic [1:0] sel, input logic [1:0] code);
      hit = (sel == code);
   endfunction

   // Source qualification; the watchdog is off while its timeout select is zero
   always_comb begin
      in_run       = (state_q == sysctl_pkg::ST_RUN);
      wr_any       = i_wr_en || i_bdm_wr;
      status_wr    = in_run && wr_any && hit(i_reg_sel, sysctl_pkg::SEL_STATUS);
      wdog_enabled = (options_q[sysctl_pkg::OPT_TSEL_HI:sysctl_pkg::OPT_TSEL_LO] != sysctl_pkg::TSEL_OFF);
      window_on    = i_watchdog_window_mode && i_watchdog_clock_sel;
      // Only the serial debug path can set the force bit; user writes never reach it
      force_src    = i_bdm_wr && hit(i_reg_sel, sysctl_pkg::SEL_DBG_FORCE) &&
                     i_wr_data[sysctl_pkg::FORCE_RESET_BIT];
      lvr_src      = i_low_volt_reset_enable && i_lvd_trip;
      pin_src      = !i_pin_reset_n;
      wdog_src     = (i_wdog_timeout && wdog_enabled) || bad_write;
      bad_opcode_flag_src     = i_opcode_illegal ||
                     (i_stop_exec && !options_q[sysctl_pkg::OPT_STOP_BIT]) ||
                     (i_bgnd_exec && !i_background_mode_allow);
      bad_address_flag_src     = i_addr_illegal;
      entry        = in_run && (force_src || lvr_src || pin_src || wdog_src || bad_opcode_flag_src || bad_address_flag_src);
   end

   // Status value captured at reset entry; debug force outranks everything
   always_comb begin
      status_d = sysctl_pkg::STATUS_CLEAR;
      if (force_src) begin
         status_d = sysctl_pkg::STATUS_CLEAR;
      end else if (lvr_src) begin
         status_d[sysctl_pkg::ST_POR_BIT] = status_q[sysctl_pkg::ST_POR_BIT];
         status_d[sysctl_pkg::ST_LVD_BIT] = 1'b1;
      end else begin
         status_d[sysctl_pkg::ST_PIN_BIT]  = pin_src;
         status_d[sysctl_pkg::ST_WDOG_BIT] = wdog_src;
         status_d[sysctl_pkg::ST_BAD_OPCODE_FLAG_BIT] = bad_opcode_flag_src;
         status_d[sysctl_pkg::ST_BAD_ADDRESS_FLAG_BIT] = bad_address_flag_src;
      end
   end

   // Watchdog service sequence
   wdog_service_seq u_svc (
      .i_sys_clk      (i_sys_clk),
      .i_rst_n        (i_rst_n),
      .i_hold         (!in_run),
      .i_wr           (status_wr),
      .i_wr_data      (i_wr_data),
      .i_wdog_enabled (wdog_enabled),
      .i_window_on    (window_on),
      .i_last_quarter (i_wdog_last_quarter),
      .o_wdog_clear   (o_wdog_clear),
      .o_bad_write    (bad_write)
   );

   // Reset sequencer: hold the part in reset while the counter runs or a level source stays active
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q     <= sysctl_pkg::ST_RUN;
         hold_cnt_q  <= '0;
         o_sys_reset <= 1'b0;
      end else begin
         unique case (state_q)
            sysctl_pkg::ST_RUN: begin
               if (entry) begin
                  state_q     <= sysctl_pkg::ST_HOLD;
                  hold_cnt_q  <= HCW'(sysctl_pkg::HOLD_CYC - 1);
                  o_sys_reset <= 1'b1;
               end
            end
            sysctl_pkg::ST_HOLD: begin
               if (hold_cnt_q != '0) begin
                  hold_cnt_q <= hold_cnt_q - HCW'(1);
               end else if (!pin_src && !lvr_src) begin
                  state_q     <= sysctl_pkg::ST_RUN;
                  o_sys_reset <= 1'b0;
               end
            end
         endcase
      end
   end

   // Status flags change only at reset entry; writes to this address never store a value
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status_q <= sysctl_pkg::STATUS_POR_VAL;
      end else if (entry) begin
         status_q <= status_d;
      end
   end

   // Marks the first cycle after power-on release, for checking only
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         after_por_q <= 1'b0;
      end else begin
         after_por_q <= 1'b1;
      end
   end

   // Write-once options: any reset reopens them, so the first write after each reset counts
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         options_q         <= sysctl_pkg::OPT_RESET_VAL;
         options_written_q <= 1'b0;
      end else if (!in_run || entry) begin
         options_q         <= sysctl_pkg::OPT_RESET_VAL;
         options_written_q <= 1'b0;
      end else if (wr_any && hit(i_reg_sel, sysctl_pkg::SEL_OPTIONS) && !options_written_q) begin
         options_q         <= i_wr_data & sysctl_pkg::OPT_WR_MASK;
         options_written_q <= 1'b1;
      end
   end

   // Option outputs; the reserved bit drives nothing
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_wdog_period_sel   <= '0;
         o_wdog_enable       <= 1'b0;
         o_stop_allow        <= 1'b0;
         o_twowire_pin_route <= 1'b0;
      end else begin
         o_wdog_period_sel   <= {i_watchdog_clock_sel,
                                 options_q[sysctl_pkg::OPT_TSEL_HI:sysctl_pkg::OPT_TSEL_LO]};
         o_wdog_enable       <= wdog_enabled;
         o_stop_allow        <= options_q[sysctl_pkg::OPT_STOP_BIT];
         o_twowire_pin_route <= options_q[sysctl_pkg::OPT_ROUTE_BIT];
      end
   end

   // Registered read data; reads have no side effect
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rd_data <= sysctl_pkg::RD_UNMAPPED;
      end else if (i_rd_en) begin
         if (hit(i_reg_sel, sysctl_pkg::SEL_STATUS)) begin
            o_rd_data <= status_q;
         end else if (hit(i_reg_sel, sysctl_pkg::SEL_DBG_FORCE)) begin
            o_rd_data <= sysctl_pkg::DBG_READ_VAL;
         end else if (hit(i_reg_sel, sysctl_pkg::SEL_OPTIONS)) begin
            o_rd_data <= options_q;
         end else begin
            o_rd_data <= sysctl_pkg::RD_UNMAPPED;
         end
      end
   end

   AST_POR_FLAGS:
      assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
         !after_por_q |-> (status_q == sysctl_pkg::STATUS_POR_VAL))
      else $error("Status after power-on is not power and low-voltage only");

   AST_FORCE_CLEARS:
      assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
         (in_run && force_src) |=> (status_q == sysctl_pkg::STATUS_CLEAR) && o_sys_reset)
      else $error("Debug forced reset left a status flag set");

   AST_FORCE_HOLDS:
      assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
         (in_run && force_src) |=> o_sys_reset [*8])
      else $error("Debug forced reset too short");

   AST_LVR_KEEPS_POR:
      assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
         (entry && !force_src && lvr_src) |=>
            status_q[sysctl_pkg::ST_LVD_BIT] &&
            (status_q[sysctl_pkg::ST_POR_BIT] == $past(status_q[sysctl_pkg::ST_POR_BIT])) &&
            !status_q[sysctl_pkg::ST_PIN_BIT])
      else $error("Low-voltage reset captured wrong flags");

   AST_PIN_FLAG:
      assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
         (entry && !force_src && !lvr_src && pin_src) |=>
            status_q[sysctl_pkg::ST_PIN_BIT] && !status_q[sysctl_pkg::ST_POR_BIT] &&
            !status_q[sysctl_pkg::ST_LVD_BIT])
      else $error("Pin reset did not set its flag");

   AST_WDOG_BLOCKED:
      assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
         (in_run && !wdog_enabled && !bad_write && !force_src && !lvr_src && !pin_src &&
          !bad_opcode_flag_src && !bad_address_flag_src) |=> !o_sys_reset)
      else $error("Watchdog reset while timeout select is zero");

   AST_BAD_WRITE_RESETS:
      assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
         (in_run && bad_write) |=> o_sys_reset && (force_src || $past(lvr_src) ||
            status_q[sysctl_pkg::ST_WDOG_BIT] || $past(force_src)))
      else $error("Illegal status write did not cause a watchdog reset");

   AST_STOP_ILLEGAL:
      assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
         (in_run && i_stop_exec && !options_q[sysctl_pkg::OPT_STOP_BIT] && !force_src && !lvr_src)
            |=> o_sys_reset && status_q[sysctl_pkg::ST_BAD_OPCODE_FLAG_BIT])
      else $error("Stop while disallowed did not force an opcode reset");

   AST_CLEAR_KEEPS_STATUS:
      assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
         (o_wdog_clear && !entry) |=> $stable(status_q))
      else $error("Watchdog service changed the status flags");

   AST_WRITE_ONCE:
      assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
         (options_written_q && in_run && !entry) |=> $stable(options_q))
      else $error("Options changed after the first write");

   AST_DBG_READS_ZERO:
      assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
         (i_rd_en && hit(i_reg_sel, sysctl_pkg::SEL_DBG_FORCE)) |=> (o_rd_data == sysctl_pkg::DBG_READ_VAL))
      else $error("Debug force register read not zero");

   AST_USER_NO_FORCE:
      assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
         (in_run && i_wr_en && !i_bdm_wr && hit(i_reg_sel, sysctl_pkg::SEL_DBG_FORCE) && !pin_src &&
          !lvr_src && !wdog_src && !bad_opcode_flag_src && !bad_address_flag_src) |=> !o_sys_reset)
      else $error("User write to debug register caused a reset");

endmodule

`default_nettype wire

// file: tb/tb_reset_status_and_options.sv
// Self-checking testbench for the reset status and system options register block
`timescale 1ns/100ps
`default_nettype none

module tb_reset_status_and_options;
   logic       i_sys_clk;
   logic       i_rst_n;
   logic [1:0] i_reg_sel;
   logic       i_wr_en;
   logic       i_bdm_wr;
   logic [7:0] i_wr_data;
   logic       i_rd_en;
   logic       i_pin_reset_n;
   logic       i_lvd_trip;
   logic       i_low_volt_reset_enable;
   logic [4:0] src;
   logic       i_background_mode_allow;
   logic       i_watchdog_clock_sel;
   logic       i_watchdog_window_mode;
   logic       i_wdog_last_quarter;
   logic [7:0] o_rd_data;
   logic       o_sys_reset;
   logic       o_wdog_clear;
   logic [2:0] o_wdog_period_sel;
   logic       o_wdog_enable;
   logic       o_stop_allow;
   logic       o_twowire_pin_route;
   int         bad_count;
   int         tests_run;

   // Pulse sources share one vector: timeout, opcode, stop, background, address
   reset_status_and_options uut (
      .i_sys_clk               (i_sys_clk),
      .i_rst_n                 (i_rst_n),
      .i_reg_sel               (i_reg_sel),
      .i_wr_en                 (i_wr_en),
      .i_bdm_wr                (i_bdm_wr),
      .i_wr_data               (i_wr_data),
      .i_rd_en                 (i_rd_en),
      .i_pin_reset_n           (i_pin_reset_n),
      .i_lvd_trip              (i_lvd_trip),
      .i_low_volt_reset_enable (i_low_volt_reset_enable),
      .i_wdog_timeout          (src[0]),
      .i_opcode_illegal        (src[1]),
      .i_stop_exec             (src[2]),
      .i_bgnd_exec             (src[3]),
      .i_background_mode_allow (i_background_mode_allow),
      .i_addr_illegal          (src[4]),
      .i_watchdog_clock_sel    (i_watchdog_clock_sel),
      .i_watchdog_window_mode  (i_watchdog_window_mode),
      .i_wdog_last_quarter     (i_wdog_last_quarter),
      .o_rd_data               (o_rd_data),
      .o_sys_reset             (o_sys_reset),
      .o_wdog_clear            (o_wdog_clear),
      .o_wdog_period_sel       (o_wdog_period_sel),
      .o_wdog_enable           (o_wdog_enable),
      .o_stop_allow            (o_stop_allow),
      .o_twowire_pin_route     (o_twowire_pin_route)
   );

   // 100 MHz clock
   always #5 i_sys_clk = ~i_sys_clk;

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   // One register write; bdm selects the debug strobe instead of the user one
   task automatic wr(input logic bdm, input logic [1:0] sel, input logic [7:0] data);
      @(negedge i_sys_clk);
      i_reg_sel = sel;
      i_wr_data = data;
      i_wr_en   = ~bdm;
      i_bdm_wr  = bdm;
      @(negedge i_sys_clk);
      i_wr_en  = 1'b0;
      i_bdm_wr = 1'b0;
   endtask

   task automatic rd(input logic [1:0] sel, input logic [7:0] exp);
      @(negedge i_sys_clk);
      i_reg_sel = sel;
      i_rd_en   = 1'b1;
      @(negedge i_sys_clk);
      i_rd_en = 1'b0;
      chk8(o_rd_data, exp, "read data");
   endtask

   // Clear pulse is one cycle; look at the two settled points after the write
   task automatic clear_seen(input logic exp);
      logic seen;
      seen = o_wdog_clear;
      @(negedge i_sys_clk);
      seen = seen | o_wdog_clear;
      chk1(seen, exp, "watchdog clear");
   endtask

   task automatic no_reset();
      logic seen;
      seen = 1'b0;
      repeat (6) begin
         @(negedge i_sys_clk);
         seen = seen | o_sys_reset;
      end
      chk1(seen, 1'b0, "unexpected reset");
   endtask

   task automatic fire(input logic [4:0] m);
      @(negedge i_sys_clk);
      src = m;
      @(negedge i_sys_clk);
      src = 5'h00;
   endtask

   // Waits for the internal reset, measures it, then reads the cause flags
   task automatic expect_reset(input logic [7:0] exp, input int min_hold);
      int n;
      n = 0;
      while (o_sys_reset !== 1'b1 && n < 8) begin
         @(negedge i_sys_clk);
         n++;
      end
      chk1(o_sys_reset, 1'b1, "reset raised");
      n = 0;
      while (o_sys_reset === 1'b1 && n < 400) begin
         @(negedge i_sys_clk);
         n++;
      end
      chk1(n + 1 >= min_hold, 1'b1, "reset length");
      rd(sysctl_pkg::SEL_STATUS, exp);
   endtask

   // Level sources keep the part in reset for as long as they stay active
   task automatic lvl_reset(input logic pin, input logic [7:0] exp);
      @(negedge i_sys_clk);
      if (pin) i_pin_reset_n = 1'b0;
      else i_lvd_trip = 1'b1;
      fork
         expect_reset(exp, 15);
         begin
            repeat (20) @(negedge i_sys_clk);
            i_pin_reset_n = 1'b1;
            i_lvd_trip    = 1'b0;
         end
      join
   endtask

   initial begin
      {i_sys_clk, i_rst_n, i_reg_sel, i_wr_en, i_bdm_wr, i_wr_data, i_rd_en} = '0;
      {i_lvd_trip, i_low_volt_reset_enable, src, i_background_mode_allow} = '0;
      {i_watchdog_clock_sel, i_watchdog_window_mode, i_wdog_last_quarter} = '0;
      i_pin_reset_n = 1'b1;
      bad_count = 0;
      tests_run = 0;
      repeat (6) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      // Power-on values and the fixed read answers
      rd(sysctl_pkg::SEL_STATUS, 8'h82);
      rd(sysctl_pkg::SEL_OPTIONS, 8'hd0);
      rd(sysctl_pkg::SEL_DBG_FORCE, 8'h00);
      rd(2'h3, 8'h00);
      chk8({5'h00, o_wdog_period_sel}, 8'h03, "period select");
      chk1(o_stop_allow, 1'b0, "stop allow");
      chk1(o_wdog_enable, 1'b1, "watchdog enable");
      chk1(o_twowire_pin_route, 1'b0, "pin route");
      // Low supply only resets when enabled; power flag survives
      i_lvd_trip = 1'b1;
      no_reset();
      i_lvd_trip = 1'b0;
      i_low_volt_reset_enable = 1'b1;
      lvl_reset(1'b0, 8'h82);
      wr(1'b0, sysctl_pkg::SEL_DBG_FORCE, 8'h01);
      no_reset();
      // Options: first write taken, later ones dropped
      wr(1'b0, sysctl_pkg::SEL_OPTIONS, 8'h24);
      rd(sysctl_pkg::SEL_OPTIONS, 8'h24);
      wr(1'b0, sysctl_pkg::SEL_OPTIONS, 8'hf4);
      rd(sysctl_pkg::SEL_OPTIONS, 8'h24);
      chk1(o_wdog_enable, 1'b0, "watchdog enable");
      chk1(o_stop_allow, 1'b1, "stop allow");
      chk1(o_twowire_pin_route, 1'b1, "pin route");
      // With the watchdog off, neither bad writes nor timeouts reset
      wr(1'b0, sysctl_pkg::SEL_STATUS, 8'h12);
      no_reset();
      fire(5'h01);
      no_reset();
      fire(5'h04);
      no_reset();
      wr(1'b1, sysctl_pkg::SEL_DBG_FORCE, 8'h00);
      no_reset();
      // Forced reset clears flags; a write during reset is ignored
      wr(1'b1, sysctl_pkg::SEL_DBG_FORCE, 8'h01);
      fork
         expect_reset(8'h00, sysctl_pkg::HOLD_CYC);
         begin
            repeat (3) @(negedge i_sys_clk);
            wr(1'b0, sysctl_pkg::SEL_OPTIONS, 8'h24);
         end
      join
      rd(sysctl_pkg::SEL_OPTIONS, 8'hd0);
      // Service sequence; an unrelated write in between does not disarm
      wr(1'b0, sysctl_pkg::SEL_STATUS, 8'haa);
      clear_seen(1'b0);
      wr(1'b0, sysctl_pkg::SEL_STATUS, 8'h55);
      clear_seen(1'b0);
      wr(1'b0, sysctl_pkg::SEL_OPTIONS, 8'hd0);
      wr(1'b0, sysctl_pkg::SEL_STATUS, 8'haa);
      clear_seen(1'b1);
      rd(sysctl_pkg::SEL_STATUS, 8'h00);
      wr(1'b0, sysctl_pkg::SEL_STATUS, 8'h12);
      expect_reset(8'h20, sysctl_pkg::HOLD_CYC);
      fire(5'h01);
      expect_reset(8'h20, sysctl_pkg::HOLD_CYC);
      fire(5'h12);
      expect_reset(8'h18, sysctl_pkg::HOLD_CYC);
      fire(5'h04);
      expect_reset(8'h10, sysctl_pkg::HOLD_CYC);
      fire(5'h08);
      expect_reset(8'h10, sysctl_pkg::HOLD_CYC);
      i_background_mode_allow = 1'b1;
      fire(5'h08);
      no_reset();
      lvl_reset(1'b1, 8'h40);
      lvl_reset(1'b0, 8'h02);
      // Timeout select joins the clock select on the period output
      i_watchdog_clock_sel = 1'b1;
      wr(1'b0, sysctl_pkg::SEL_OPTIONS, 8'h64);
      rd(sysctl_pkg::SEL_OPTIONS, 8'h64);
      chk8({5'h00, o_wdog_period_sel}, 8'h05, "period select");
      // Window mode: early status write resets, late service clears
      i_watchdog_window_mode = 1'b1;
      wr(1'b0, sysctl_pkg::SEL_STATUS, 8'h55);
      expect_reset(8'h20, sysctl_pkg::HOLD_CYC);
      i_wdog_last_quarter = 1'b1;
      wr(1'b0, sysctl_pkg::SEL_STATUS, 8'h55);
      wr(1'b0, sysctl_pkg::SEL_STATUS, 8'haa);
      clear_seen(1'b1);
      no_reset();
      print_verdict();
   end

   // Whole sequence needs a few hundred cycles; this is far beyond it
   initial begin
      #200us;
      bad_count++;
      $display("ERROR %0t: run did not finish", $time);
      print_verdict();
   end
endmodule
`default_nettype wire
